//--- verif/sarc_top_tb.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
module sarc_top_tb import sarc_pkg::*;;
	logic              aclk, aresetn, stop_mode;
	logic [7:0]        s_axi_awaddr, s_axi_araddr, sar_value, last_res;
	logic [2:0]        s_axi_awprot, s_axi_arprot;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0]       s_axi_wdata, s_axi_rdata;
	logic [3:0]        s_axi_wstrb, channel_select, kk;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic              s_axi_rvalid, s_axi_rready, analog_input_disable;
	logic              ladder_connect, conv_active, conv_done_irq, seen;
	int                err_count, num_checks, cyc, t_take, k;
	logic [33:0]       exp_q[$];
	logic [31:0]       msk_q[$];
	logic [2:0]        codes[4] = '{SARC_TIME_78, SARC_TIME_156, SARC_TIME_312, 3'h0};
	int                lens[4] = '{78, 156, 312, 312};

	sarc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .stop_mode, .sar_value, .channel_select, .analog_input_disable,
		.ladder_connect, .conv_active, .conv_done_irq);

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk) cyc <= cyc + 1;

	task automatic final_report;
		$display("checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic hang;
		err_count++;
		$display("wrong value at %0t: wait bound used up", $time);
		final_report();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Oldest note is matched against each accepted read answer
	always @(posedge aclk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk(32'h1, 32'h0, "unexpected read answer");
			end else begin
				chk(s_axi_rdata & msk_q[0], exp_q[0][31:0], "read data");
				chk({30'h0, s_axi_rresp}, {30'h0, exp_q[0][33:32]}, "read resp");
				void'(exp_q.pop_front());
				void'(msk_q.pop_front());
			end
		end
	end
	// Extra edge at the end keeps strobes from being set twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
		int c;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'($urandom()), d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		c = 0;
		do begin @(posedge aclk); c++; end while (s_axi_awready !== 1'b1 && c < 50);
		if (c >= 50) hang();
		t_take = cyc;
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid  <= 1'b0;
		do begin @(posedge aclk); c++; end while (s_axi_bvalid !== 1'b1 && c < 99);
		if (c >= 99) hang();
		chk({30'h0, s_axi_bresp}, {30'h0, resp}, "write resp");
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] resp, input logic [7:0] d,
		input logic [7:0] m);
		int c;
		exp_q.push_back({resp, 24'h0, d & m});
		msk_q.push_back({24'hFFFFFF, m});
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		c = 0;
		do begin @(posedge aclk); c++; end while (s_axi_arready !== 1'b1 && c < 50);
		if (c >= 50) hang();
		s_axi_arvalid <= 1'b0;
		do begin @(posedge aclk); c++; end while (s_axi_rvalid !== 1'b1 && c < 99);
		if (c >= 99) hang();
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	// Start, look while busy, then time the completion pulse
	task automatic convert(input logic [2:0] code, input int n, input logic [3:0] ch);
		int c;
		wr(SARC_ADDR_CTRL2, {4'h1, code, 1'b0}, SARC_RESP_OKAY);
		sar_value <= 8'($urandom());
		wr(SARC_ADDR_CTRL1, {4'hA, ch}, SARC_RESP_OKAY);
		rd(SARC_ADDR_STATUS, SARC_RESP_OKAY, 8'h10, 8'h30);
		rd(SARC_ADDR_CTRL1, SARC_RESP_OKAY, {4'h2, ch}, 8'hFF);
		rd(SARC_ADDR_RESULT, SARC_RESP_OKAY, last_res, 8'hFF);
		chk({31'h0, ladder_connect}, 32'h1, "ladder while busy");
		c = 0;
		// No new start until the completion pulse
		do begin @(posedge aclk); c++; end while (conv_done_irq !== 1'b1 && c < 400);
		if (c >= 400) hang();
		chk(32'(cyc - t_take), 32'(n + 1), "conversion length");
		last_res = sar_value;
		@(posedge aclk);
		chk({31'h0, conv_done_irq}, 32'h0, "irq one cycle");
	endtask

	initial begin
		{s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot} = '0;
		{s_axi_arvalid, s_axi_rready, stop_mode, sar_value} = '0;
		{aresetn, err_count, num_checks, last_res} = '0;
		s_axi_wstrb = 4'h1;
		void'($urandom(62273));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({27'h0, analog_input_disable, channel_select}, 32'h10, "pins at reset");
		rd(SARC_ADDR_CTRL1, SARC_RESP_OKAY, 8'h10, 8'hFF);
		rd(SARC_ADDR_CTRL2, SARC_RESP_OKAY, 8'h00, 8'h3F);
		rd(SARC_ADDR_RESULT, SARC_RESP_OKAY, 8'h00, 8'hFF);
		rd(SARC_ADDR_STATUS, SARC_RESP_OKAY, 8'h00, 8'h30);
		wr(8'h40, 8'hFF, SARC_RESP_SLVERR);
		rd(8'h40, SARC_RESP_SLVERR, 8'h00, 8'hFF);
		for (k = 0; k < 16; k++) begin
			kk = 4'(k);
			wr(SARC_ADDR_CTRL1, {3'b001, kk[0], kk}, SARC_RESP_OKAY);
			chk({27'h0, analog_input_disable, channel_select}, {27'h0, kk[0], kk}, "pins");
		end
		wr(SARC_ADDR_CTRL2, 8'h30, SARC_RESP_OKAY);
		chk({31'h0, ladder_connect}, 32'h1, "ladder held");
		wr(SARC_ADDR_CTRL2, 8'h10, SARC_RESP_OKAY);
		chk({31'h0, ladder_connect}, 32'h0, "ladder idle");
		for (k = 0; k < 4; k++) begin
			convert(codes[k], lens[k], 4'(k + 2));
			rd(SARC_ADDR_STATUS, SARC_RESP_OKAY, 8'h20, 8'h30);
			rd(SARC_ADDR_RESULT, SARC_RESP_OKAY, last_res, 8'hFF);
			rd(SARC_ADDR_STATUS, SARC_RESP_OKAY, 8'h00, 8'h30);
		end
		wr(SARC_ADDR_RESULT, ~last_res, SARC_RESP_OKAY);
		rd(SARC_ADDR_RESULT, SARC_RESP_OKAY, last_res, 8'hFF);
		// Second start without reading the first result
		convert(SARC_TIME_78, 78, 4'h5);
		convert(SARC_TIME_78, 78, 4'h3);
		wr(SARC_ADDR_CTRL2, 8'h38, SARC_RESP_OKAY);
		wr(SARC_ADDR_CTRL1, 8'hA4, SARC_RESP_OKAY);
		repeat (20) @(posedge aclk);
		stop_mode <= 1'b1;
		wr(SARC_ADDR_CTRL1, 8'h25, SARC_RESP_OKAY);
		wr(SARC_ADDR_CTRL2, 8'h3E, SARC_RESP_OKAY);
		stop_mode <= 1'b0;
		@(posedge aclk);
		chk({30'h0, conv_active, ladder_connect}, 32'h0, "stopped");
		rd(SARC_ADDR_CTRL1, SARC_RESP_OKAY, 8'h10, 8'hFF);
		rd(SARC_ADDR_CTRL2, SARC_RESP_OKAY, 8'h00, 8'h3F);
		rd(SARC_ADDR_STATUS, SARC_RESP_OKAY, 8'h00, 8'h30);
		rd(SARC_ADDR_RESULT, SARC_RESP_OKAY, 8'h00, 8'hFF);
		seen = 1'b0;
		repeat (330) @(posedge aclk) seen = seen | conv_done_irq;
		chk({31'h0, seen}, 32'h0, "no restart after stop");
		final_report();
	end
	initial begin
		repeat (60000) @(posedge aclk);
		hang();
	end
endmodule

//--- verilog/sarc_pkg.sv
// Register map, field layout and timing constants of the converter control
package sarc_pkg;
	localparam int          SARC_ADDR_W       = 8;
	// Register indexes; byte address is four times the index
	localparam logic [5:0]  SARC_IDX_CTRL1    = 6'h0E;
	localparam logic [5:0]  SARC_IDX_CTRL2    = 6'h0F;
	localparam logic [5:0]  SARC_IDX_RESULT   = 6'h20;
	localparam logic [5:0]  SARC_IDX_STATUS   = 6'h21;
	localparam logic [7:0]  SARC_ADDR_CTRL1   = {SARC_IDX_CTRL1, 2'b00};
	localparam logic [7:0]  SARC_ADDR_CTRL2   = {SARC_IDX_CTRL2, 2'b00};
	localparam logic [7:0]  SARC_ADDR_RESULT  = {SARC_IDX_RESULT, 2'b00};
	localparam logic [7:0]  SARC_ADDR_STATUS  = {SARC_IDX_STATUS, 2'b00};
	// Control one fields
	localparam int          SARC_START_BIT    = 7;
	localparam int          SARC_AIN_DIS_BIT  = 4;
	localparam int          SARC_CHAN_LSB     = 0;
	localparam int          SARC_CHAN_W       = 4;
	localparam logic [7:0]  SARC_CTRL1_RESET  = 8'h10;
	localparam logic [7:0]  SARC_CTRL1_MASK   = 8'h7F;
	localparam logic [3:0]  SARC_CHAN_FIRST   = 4'h2;
	localparam logic [3:0]  SARC_CHAN_LAST    = 4'h5;
	// Control two fields
	localparam int          SARC_LADDER_BIT   = 5;
	localparam int          SARC_TIME_LSB     = 1;
	localparam int          SARC_TIME_W       = 3;
	localparam logic [7:0]  SARC_CTRL2_RESET  = 8'h00;
	localparam logic [7:0]  SARC_CTRL2_MASK   = 8'h3F;
	localparam logic [2:0]  SARC_TIME_78      = 3'h2;
	localparam logic [2:0]  SARC_TIME_156     = 3'h3;
	localparam logic [2:0]  SARC_TIME_312     = 3'h4;
	// Status fields
	localparam int          SARC_EOC_BIT      = 5;
	localparam int          SARC_BUSY_BIT     = 4;
	localparam logic [7:0]  SARC_RESULT_RESET = 8'h00;
	// Conversion times in fc periods; fc is aclk here
	localparam int          SARC_FC_PER_CLK   = 1;
	localparam int          SARC_T78_FC       = 78;
	localparam int          SARC_T156_FC      = 156;
	localparam int          SARC_T312_FC      = 312;
	localparam logic [8:0]  SARC_CYC_78       = 9'(SARC_T78_FC / SARC_FC_PER_CLK);
	localparam logic [8:0]  SARC_CYC_156      = 9'(SARC_T156_FC / SARC_FC_PER_CLK);
	localparam logic [8:0]  SARC_CYC_312      = 9'(SARC_T312_FC / SARC_FC_PER_CLK);
	localparam logic [1:0]  SARC_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  SARC_RESP_SLVERR  = 2'h2;
	typedef enum logic {SARC_IDLE, SARC_CONV} sarc_state_e;
endpackage

//--- verilog/sarc_top.sv
// SAR converter control and status registers behind an AXI4-Lite slave
// How it works
// [RULE_01] Writing start bit one begins conversion
// [RULE_02] Start bit self-clears, always reads zero
// [RULE_03] Software never restarts during running conversion
// [RULE_04] Input control bit one disables analog inputs
// [RULE_05] Channel field codes two to five valid
// [RULE_06] Software changes channel only while idle
// [RULE_07] Software writes bit5 one, bit6 zero
// [RULE_08] Reset leaves reserved channel code selected
// [RULE_09] Stop mode resets controls, blocks writes
// [RULE_10] Time field selects 78, 156, 312 periods
// [RULE_11] Software writes bit0 zero, bit4 one
// [RULE_12] Control two bits 7:6 undefined on read
// [RULE_13] Result register holds eight-bit value, read-only
// [RULE_14] Completion flag set only after conversion ends
// [RULE_15] Reading result clears completion flag
// [RULE_16] Software reads status before result
// [RULE_17] Busy high during conversion, cleared by stop
// [RULE_18] Status bits beside two flags meaningless
// [RULE_19] Completion writes result, flag, interrupt together
// [RULE_20] Restart clears flag, keeps old result
// [RULE_21] Stop aborts conversion, result indeterminate
// [RULE_22] Ladder bit keeps ladder always connected
// [RULE_23] Busy falls after selected period count
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module sarc_top import sarc_pkg::*; (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [SARC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]             s_axi_awprot,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [SARC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]             s_axi_arprot,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic                   stop_mode,
	input  wire logic [7:0]             sar_value,
	output logic [SARC_CHAN_W-1:0]      channel_select,
	output logic                        analog_input_disable,
	output logic                        ladder_connect,
	output logic                        conv_active,
	output logic                        conv_done_irq
);
	logic [7:0]       ctrl1_reg, ctrl1_next;
	logic [7:0]       ctrl2_reg, ctrl2_next;
	logic [7:0]       result_reg, result_next;
	logic             eoc_reg, eoc_next;
	logic             irq_reg, irq_next;
	logic [8:0]       cnt_reg, cnt_next;
	sarc_state_e      state_reg, state_next;
	logic             bvalid_reg, bvalid_next;
	logic [1:0]       bresp_reg, bresp_next;
	logic             rvalid_reg, rvalid_next;
	logic [1:0]       rresp_reg, rresp_next;
	logic [31:0]      rdata_reg, rdata_next;
	logic             wr_take, rd_take, wr_low, start_req, conv_end;
	logic [8:0]       conv_len;
	logic [SARC_TIME_W-1:0] time_code;

	// Both write channels taken together; one write under way at a time
	assign wr_take       = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign s_axi_awready = wr_take;
	assign s_axi_wready  = wr_take;
	assign rd_take       = s_axi_arvalid && !rvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign wr_low        = wr_take && s_axi_wstrb[0];
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;

	// [RULE_01] start on written one
	// Restart while busy is dropped, so only stop mode can cut a running conversion short
	assign start_req = wr_low && !stop_mode && (s_axi_awaddr == SARC_ADDR_CTRL1)
		&& s_axi_wdata[SARC_START_BIT] && (state_reg == SARC_IDLE);
	assign time_code = ctrl2_reg[SARC_TIME_LSB +: SARC_TIME_W];

	// [RULE_10] time code to cycles
	// Reserved codes fall back to the longest time
	always_comb begin
		unique case (time_code)
			SARC_TIME_78:  conv_len = SARC_CYC_78;
			SARC_TIME_156: conv_len = SARC_CYC_156;
			default:       conv_len = SARC_CYC_312;
		endcase
	end

	// [RULE_23] end after counted periods
	assign conv_end = (state_reg == SARC_CONV) && (cnt_reg == 9'h000) && !stop_mode;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		if (stop_mode) begin
			// [RULE_21] stop aborts conversion
			state_next = SARC_IDLE;
			cnt_next   = 9'h000;
		end else if (start_req) begin
			state_next = SARC_CONV;
			cnt_next   = conv_len - 9'h001;
		end else if (conv_end) begin
			state_next = SARC_IDLE;
		end else if (state_reg == SARC_CONV) begin
			cnt_next = cnt_reg - 9'h001;
		end
	end

	always_comb begin
		ctrl1_next  = ctrl1_reg;
		ctrl2_next  = ctrl2_reg;
		result_next = result_reg;
		eoc_next    = eoc_reg;
		irq_next    = 1'b0;
		if (stop_mode) begin
			// [RULE_09] stop forces initial values
			ctrl1_next  = SARC_CTRL1_RESET;
			ctrl2_next  = SARC_CTRL2_RESET;
			// [RULE_21] result left cleared
			result_next = SARC_RESULT_RESET;
			eoc_next    = 1'b0;
		end else begin
			// [RULE_02] start bit never stored
			if (wr_low && s_axi_awaddr == SARC_ADDR_CTRL1)
				ctrl1_next = s_axi_wdata[7:0] & SARC_CTRL1_MASK;
			if (wr_low && s_axi_awaddr == SARC_ADDR_CTRL2)
				ctrl2_next = s_axi_wdata[7:0] & SARC_CTRL2_MASK;
			// [RULE_15] result read clears flag
			if (rd_take && s_axi_araddr == SARC_ADDR_RESULT)
				eoc_next = 1'b0;
			// [RULE_20] restart clears flag only
			if (start_req)
				eoc_next = 1'b0;
			// [RULE_19] result, flag, interrupt together
			// Set wins over a clearing read in the same cycle
			if (conv_end) begin
				result_next = sar_value;
				eoc_next    = 1'b1;
				irq_next    = 1'b1;
			end
		end
	end

	always_comb begin
		bvalid_next = bvalid_reg;
		bresp_next  = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next  = rresp_reg;
		rdata_next  = rdata_reg;
		if (bvalid_reg && s_axi_bready)
			bvalid_next = 1'b0;
		if (wr_take) begin
			bvalid_next = 1'b1;
			bresp_next  = (s_axi_awaddr == SARC_ADDR_CTRL1 || s_axi_awaddr == SARC_ADDR_CTRL2
				|| s_axi_awaddr == SARC_ADDR_RESULT || s_axi_awaddr == SARC_ADDR_STATUS)
				? SARC_RESP_OKAY : SARC_RESP_SLVERR;
		end
		if (rvalid_reg && s_axi_rready)
			rvalid_next = 1'b0;
		if (rd_take) begin
			rvalid_next = 1'b1;
			rresp_next  = SARC_RESP_OKAY;
			rdata_next  = 32'h0000_0000;
			unique case (s_axi_araddr)
				SARC_ADDR_CTRL1:  rdata_next[7:0] = ctrl1_reg;
				// [RULE_12] bits 7:6 read zero
				SARC_ADDR_CTRL2:  rdata_next[7:0] = ctrl2_reg;
				// [RULE_13] read-only result
				SARC_ADDR_RESULT: rdata_next[7:0] = result_reg;
				// [RULE_14] [RULE_17] [RULE_18] two flags only
				SARC_ADDR_STATUS: begin
					rdata_next[SARC_EOC_BIT]  = eoc_reg;
					rdata_next[SARC_BUSY_BIT] = (state_reg == SARC_CONV);
				end
				default:          rresp_next = SARC_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// [RULE_08] reserved channel after reset
			ctrl1_reg  <= SARC_CTRL1_RESET;
			ctrl2_reg  <= SARC_CTRL2_RESET;
			result_reg <= SARC_RESULT_RESET;
			eoc_reg    <= 1'b0;
			irq_reg    <= 1'b0;
			cnt_reg    <= 9'h000;
			state_reg  <= SARC_IDLE;
			bvalid_reg <= 1'b0;
			bresp_reg  <= SARC_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg  <= SARC_RESP_OKAY;
			rdata_reg  <= 32'h0000_0000;
		end else begin
			ctrl1_reg  <= ctrl1_next;
			ctrl2_reg  <= ctrl2_next;
			result_reg <= result_next;
			eoc_reg    <= eoc_next;
			irq_reg    <= irq_next;
			cnt_reg    <= cnt_next;
			state_reg  <= state_next;
			bvalid_reg <= bvalid_next;
			bresp_reg  <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg  <= rresp_next;
			rdata_reg  <= rdata_next;
		end
	end

	// [RULE_05] channel code to analog mux
	assign channel_select       = ctrl1_reg[SARC_CHAN_LSB +: SARC_CHAN_W];
	// [RULE_04] input disable to pads
	assign analog_input_disable = ctrl1_reg[SARC_AIN_DIS_BIT];
	// [RULE_22] ladder during conversion or always
	assign ladder_connect       = (state_reg == SARC_CONV) || ctrl2_reg[SARC_LADDER_BIT];
	assign conv_active          = (state_reg == SARC_CONV);
	assign conv_done_irq        = irq_reg;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_start_busy: assert property (start_req |=> conv_active) // [RULE_01]
		else $error("Start did not raise busy");
	a_start_clear: assert property (rd_take && s_axi_araddr == SARC_ADDR_CTRL1
		|=> !rdata_reg[SARC_START_BIT]) // [RULE_02]
		else $error("Start bit read back as one");
	a_stop_init: assert property (stop_mode |=> ctrl1_reg == SARC_CTRL1_RESET
		&& ctrl2_reg == SARC_CTRL2_RESET && !conv_active) // [RULE_09]
		else $error("Stop did not initialise controls");
	a_time_78: assert property (start_req && time_code == SARC_TIME_78 && !stop_mode
		##1 (!stop_mode)[*8] |-> conv_active) // [RULE_10]
		else $error("Short conversion ended early");
	a_conv_len: assert property (start_req && time_code == SARC_TIME_78
		##1 (!stop_mode throughout ##77 1) |=> !conv_active && eoc_reg) // [RULE_23]
		else $error("Conversion length wrong");
	a_ctrl2_upper: assert property (rd_take && s_axi_araddr == SARC_ADDR_CTRL2
		|=> rdata_reg[7:6] == 2'b00) // [RULE_12]
		else $error("Control two upper bits not zero");
	a_eoc_busy: assert property (conv_active |-> !eoc_reg) // [RULE_14]
		else $error("Completion flag set while busy");
	a_read_clear: assert property (rd_take && s_axi_araddr == SARC_ADDR_RESULT
		&& !conv_end && !stop_mode |=> !eoc_reg) // [RULE_15]
		else $error("Result read left flag set");
	a_done_step: assert property (conv_end |=> conv_done_irq && eoc_reg
		&& result_reg == $past(sar_value)) // [RULE_19]
		else $error("Completion effects not together");
	a_keep_result: assert property (start_req |=> result_reg == $past(result_reg)) // [RULE_20]
		else $error("Restart changed result");
	a_stop_abort: assert property (conv_active && stop_mode |=> !conv_active
		&& !conv_done_irq) // [RULE_21]
		else $error("Stop did not abort");
	a_ladder_on: assert property (ctrl2_reg[SARC_LADDER_BIT] |-> ladder_connect) // [RULE_22]
		else $error("Ladder not held connected");

	c_conv_done: cover property (start_req ##[1:400] conv_done_irq);
	c_restart: cover property (conv_done_irq ##[1:50] start_req);
	c_stop_abort: cover property (conv_active && stop_mode);
	c_set_wins: cover property (conv_end && rd_take && s_axi_araddr == SARC_ADDR_RESULT);
endmodule
